/* otpa_regs.svh */
// Constants for the one-time-programmable area host controller.
// Assumes an x8 asynchronous command/address/data bus toward the device.
`ifndef OTPA_REGS_SVH
`define OTPA_REGS_SVH
// ****************************************
// Host register map (word addresses)
// ****************************************
`define OTPA_ADDR_CTRL 4'h0
`define OTPA_ADDR_PAGE 4'h1
`define OTPA_ADDR_COL 4'h2
`define OTPA_ADDR_WDATA 4'h3
`define OTPA_ADDR_RDATA 4'h4
`define OTPA_ADDR_STATUS 4'h5
`define OTPA_ADDR_COUNT 4'h6
// ****************************************
// Control fields
// ****************************************
`define OTPA_CTRL_OP_LSB 0
`define OTPA_CTRL_OP_MSB 2
`define OTPA_OP_ENTER 3'h1
`define OTPA_OP_PROTECT_MODE 3'h2
`define OTPA_OP_EXIT 3'h3
`define OTPA_OP_PROGRAM 3'h4
`define OTPA_OP_READ 3'h5
`define OTPA_OP_RAND_IN 3'h6
`define OTPA_OP_RAND_OUT 3'h7
// ****************************************
// Device command codes
// ****************************************
`define OTPA_CMD_SET_FEAT 8'hef
`define OTPA_FEAT_ADDR 8'h90
`define OTPA_P1_OTP 8'h01
`define OTPA_P1_PROTECT 8'h03
`define OTPA_P1_EXIT 8'h00
`define OTPA_CMD_READ1 8'h00
`define OTPA_CMD_READ2 8'h30
`define OTPA_CMD_PROG1 8'h80
`define OTPA_CMD_PROG2 8'h10
`define OTPA_CMD_RIN 8'h85
`define OTPA_CMD_ROUT1 8'h05
`define OTPA_CMD_ROUT2 8'he0
`define OTPA_CMD_STATUS 8'h70
`define OTPA_PAGE_FIRST 8'h02
`define OTPA_PAGE_LAST 8'h1f
`define OTPA_MAX_PARTIAL 3'h4
`define OTPA_ST_FAIL_BIT 0
`define OTPA_ST_READY_BIT 5
// ****************************************
// Timing (10 MHz clock)
// ****************************************
`define OTPA_CLK_NS 100
`define OTPA_STROBE_NS 100
`define OTPA_STROBE_CYC 2'h1
`define OTPA_WB_NS 200
`define OTPA_WB_CYC 3'((`OTPA_WB_NS + `OTPA_CLK_NS - 1) / `OTPA_CLK_NS)
`endif

/* otpa_pkg.sv */
// Types for the one-time-programmable area host controller.
// Assumes otpa_regs.svh holds the register, command and timing numbers; the state codes stand here.
package otpa_pkg;
	typedef enum logic [8:0] {
		OTPA_IDLE = 9'h001,
		OTPA_CMD = 9'h002,
		OTPA_ADR = 9'h004,
		OTPA_DOUT = 9'h008,
		OTPA_CMD2 = 9'h010,
		OTPA_WAIT = 9'h020,
		OTPA_STAT = 9'h040,
		OTPA_DIN = 9'h080,
		OTPA_GAP = 9'h100
	} otpa_state_t;
endpackage

/* otpa_host.sv */
// Host controller driving a NAND device's one-time-programmable area.
// Assumes an x8 asynchronous NAND bus sampled on clk_in; bus pins are synchronous.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "otpa_regs.svh"
module otpa_host
	import otpa_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// NAND bus
	output logic nand_ce_n_out,
	output logic nand_cle_out,
	output logic nand_ale_out,
	output logic nand_we_n_out,
	output logic read_strobe_n_out,
	input wire logic [7:0] nand_io_in,
	output logic [7:0] nand_io_out,
	output logic nand_io_oe_out,
	input wire logic nand_ready_in
);
	// ****************************************
	// Registers
	// ****************************************
	otpa_state_t state_q;
	logic [2:0] op_q;
	logic [7:0] page_q;
	logic [12:0] column_offset_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic [7:0] status_q;
	logic [7:0] count_q;
	logic [2:0] idx_q;
	logic [1:0] phase_q;
	logic [2:0] gap_q;
	logic busy_q;
	logic done_q;
	logic pass_q;
	logic protected_q;
	logic otp_mode_q;
	logic protect_mode_q;
	logic refused_q;
	logic [2:0] partial_q;
	logic [7:0] last_page_q;
	logic [7:0] byte_d;
	logic start;
	logic [2:0] op_start;

	// Decode of an operation that finishes with a status check
	function automatic logic op_checks_status(input logic [2:0] op);
		op_checks_status = (op == `OTPA_OP_PROGRAM) || (op == `OTPA_OP_READ);
	endfunction

	// Legal page and write order for a program
	function automatic logic prog_allowed(input logic [7:0] pg, input logic [7:0] last,
			input logic [2:0] parts, input logic pmode);
		if (pmode) begin
			prog_allowed = 1'b1;
		end else begin
			prog_allowed = (pg >= `OTPA_PAGE_FIRST) && (pg <= `OTPA_PAGE_LAST)
				&& (pg >= last)
				&& ((pg != last) || (parts < `OTPA_MAX_PARTIAL));
		end
	endfunction

	assign start = reg_wr_in && (reg_addr_in == `OTPA_ADDR_CTRL) && !busy_q;
	assign op_start = reg_wdata_in[`OTPA_CTRL_OP_MSB:`OTPA_CTRL_OP_LSB];

	// ****************************************
	// Register read port
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 32'h0;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`OTPA_ADDR_CTRL: reg_rdata_out <= {29'h0, op_q};
				`OTPA_ADDR_PAGE: reg_rdata_out <= {24'h0, page_q};
				`OTPA_ADDR_COL: reg_rdata_out <= {19'h0, column_offset_q};
				`OTPA_ADDR_WDATA: reg_rdata_out <= {24'h0, wdata_q};
				`OTPA_ADDR_RDATA: reg_rdata_out <= {24'h0, rdata_q};
				`OTPA_ADDR_STATUS: reg_rdata_out <= {16'h0, status_q, refused_q, protect_mode_q,
					otp_mode_q, protected_q, pass_q, done_q, busy_q, nand_ready_in};
				`OTPA_ADDR_COUNT: reg_rdata_out <= {24'h0, count_q};
				default: reg_rdata_out <= 32'h0;
			endcase
		end else begin
			reg_rdata_out <= 32'h0;
		end
	end

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			page_q <= 8'h0;
			column_offset_q <= 13'h0;
			wdata_q <= 8'hff;
			count_q <= 8'h1;
		end else if (reg_wr_in && !busy_q) begin
			case (reg_addr_in)
				`OTPA_ADDR_PAGE: page_q <= reg_wdata_in[7:0];
				`OTPA_ADDR_COL: column_offset_q <= reg_wdata_in[12:0];
				`OTPA_ADDR_WDATA: wdata_q <= reg_wdata_in[7:0];
				`OTPA_ADDR_COUNT: count_q <= reg_wdata_in[7:0];
				default: count_q <= count_q;
			endcase
		end
	end

	// ****************************************
	// Byte presented on the bus per step
	// ****************************************
	always_comb begin
		byte_d = 8'h0;
		case (state_q)
			OTPA_CMD: begin
				case (op_q)
					`OTPA_OP_ENTER, `OTPA_OP_PROTECT_MODE, `OTPA_OP_EXIT:
						byte_d = `OTPA_CMD_SET_FEAT;
					`OTPA_OP_PROGRAM: byte_d = `OTPA_CMD_PROG1;
					`OTPA_OP_RAND_IN: byte_d = `OTPA_CMD_RIN;
					`OTPA_OP_RAND_OUT: byte_d = `OTPA_CMD_ROUT1;
					default: byte_d = `OTPA_CMD_READ1;
				endcase
			end
			OTPA_ADR: begin
				if (op_q == `OTPA_OP_ENTER || op_q == `OTPA_OP_PROTECT_MODE
						|| op_q == `OTPA_OP_EXIT) begin
					byte_d = `OTPA_FEAT_ADDR;
				end else if (protect_mode_q && op_q == `OTPA_OP_PROGRAM) begin
					byte_d = 8'h0;
				end else begin
					case (idx_q)
						3'h0: byte_d = column_offset_q[7:0];
						3'h1: byte_d = {3'h0, column_offset_q[12:8]};
						3'h2: byte_d = page_q;
						default: byte_d = 8'h0;
					endcase
				end
			end
			OTPA_DOUT: begin
				if (op_q == `OTPA_OP_ENTER && idx_q == 3'h0) begin
					byte_d = `OTPA_P1_OTP;
				end else if (op_q == `OTPA_OP_PROTECT_MODE && idx_q == 3'h0) begin
					byte_d = `OTPA_P1_PROTECT;
				end else if (op_q == `OTPA_OP_EXIT && idx_q == 3'h0) begin
					byte_d = `OTPA_P1_EXIT;
				end else if (op_q == `OTPA_OP_ENTER || op_q == `OTPA_OP_PROTECT_MODE
						|| op_q == `OTPA_OP_EXIT) begin
					byte_d = 8'h0;
				end else begin
					byte_d = protect_mode_q ? 8'h0 : wdata_q;
				end
			end
			OTPA_CMD2: begin
				case (op_q)
					`OTPA_OP_READ: byte_d = `OTPA_CMD_READ2;
					`OTPA_OP_RAND_OUT: byte_d = `OTPA_CMD_ROUT2;
					default: byte_d = `OTPA_CMD_PROG2;
				endcase
			end
			OTPA_STAT: byte_d = `OTPA_CMD_STATUS;
			default: byte_d = 8'h0;
		endcase
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= OTPA_IDLE;
			op_q <= 3'h0;
			idx_q <= 3'h0;
			phase_q <= 2'h0;
			gap_q <= 3'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			pass_q <= 1'b0;
			rdata_q <= 8'h0;
			status_q <= 8'h0;
			protected_q <= 1'b0;
			otp_mode_q <= 1'b0;
			protect_mode_q <= 1'b0;
			refused_q <= 1'b0;
			partial_q <= 3'h0;
			last_page_q <= 8'h0;
			nand_ce_n_out <= 1'b1;
			nand_cle_out <= 1'b0;
			nand_ale_out <= 1'b0;
			nand_we_n_out <= 1'b1;
			read_strobe_n_out <= 1'b1;
			nand_io_out <= 8'h0;
			nand_io_oe_out <= 1'b0;
		end else begin
			case (state_q)
				OTPA_IDLE: begin
					nand_ce_n_out <= 1'b1;
					if (start) begin
						op_q <= op_start;
						done_q <= 1'b0;
						refused_q <= 1'b0;
						if (op_start == `OTPA_OP_PROGRAM && (protected_q
								|| !prog_allowed(page_q, last_page_q, partial_q,
								protect_mode_q))) begin
							refused_q <= 1'b1;
							done_q <= 1'b1;
						end else if (op_start != 3'h0 && (otp_mode_q || protect_mode_q
								|| op_start <= `OTPA_OP_EXIT)) begin
							busy_q <= 1'b1;
							idx_q <= 3'h0;
							phase_q <= 2'h0;
							state_q <= OTPA_CMD;
						end else begin
							refused_q <= 1'b1;
							done_q <= 1'b1;
						end
					end
				end
				OTPA_CMD, OTPA_ADR, OTPA_DOUT, OTPA_CMD2, OTPA_STAT: begin
					// Two cycles per write: strobe low, then rising edge latches
					nand_ce_n_out <= 1'b0;
					nand_cle_out <= (state_q == OTPA_CMD) || (state_q == OTPA_CMD2)
						|| (state_q == OTPA_STAT);
					nand_ale_out <= (state_q == OTPA_ADR);
					nand_io_out <= byte_d;
					nand_io_oe_out <= 1'b1;
					phase_q <= phase_q + 2'h1;
					nand_we_n_out <= (phase_q != 2'h0);
					if (phase_q == `OTPA_STROBE_CYC) begin
						phase_q <= 2'h0;
						idx_q <= idx_q + 3'h1;
						case (state_q)
							OTPA_CMD: begin
								idx_q <= 3'h0;
								state_q <= OTPA_ADR;
							end
							OTPA_ADR: begin
								if (op_q == `OTPA_OP_ENTER || op_q == `OTPA_OP_PROTECT_MODE
										|| op_q == `OTPA_OP_EXIT) begin
									idx_q <= 3'h0;
									state_q <= OTPA_DOUT;
								end else if ((op_q == `OTPA_OP_RAND_IN
										|| op_q == `OTPA_OP_RAND_OUT) && idx_q == 3'h1) begin
									idx_q <= 3'h0;
									state_q <= (op_q == `OTPA_OP_RAND_IN) ? OTPA_DOUT
										: OTPA_CMD2;
								end else if (protect_mode_q && op_q == `OTPA_OP_PROGRAM
										&& idx_q == 3'h3) begin
									idx_q <= 3'h0;
									state_q <= OTPA_DOUT;
								end else if (idx_q == 3'h4) begin
									idx_q <= 3'h0;
									state_q <= (op_q == `OTPA_OP_READ) ? OTPA_CMD2
										: OTPA_DOUT;
								end
							end
							OTPA_DOUT: begin
								if (op_q <= `OTPA_OP_EXIT) begin
									if (idx_q == 3'h3) begin
										state_q <= OTPA_GAP;
									end
								end else if ({5'h0, idx_q} + 8'h1 >= count_q) begin
									// RAND_IN leaves the page open for more
									state_q <= (op_q == `OTPA_OP_RAND_IN) ? OTPA_GAP
										: OTPA_CMD2;
								end
							end
							OTPA_CMD2: begin
								state_q <= (op_q == `OTPA_OP_RAND_OUT) ? OTPA_GAP
									: OTPA_WAIT;
							end
							default: begin
								state_q <= OTPA_GAP;
							end
						endcase
						gap_q <= `OTPA_WB_CYC;
					end
				end
				OTPA_WAIT: begin
					// Busy covers program, protect-mode program and page read
					nand_cle_out <= 1'b0;
					nand_io_oe_out <= 1'b0;
					if (gap_q != 3'h0) begin
						gap_q <= gap_q - 3'h1;
					end else if (nand_ready_in) begin
						state_q <= OTPA_STAT;
					end
				end
				OTPA_GAP: begin
					nand_cle_out <= 1'b0;
					nand_ale_out <= 1'b0;
					nand_we_n_out <= 1'b1;
					nand_io_oe_out <= 1'b0;
					if (idx_q == 3'h1 && state_q == OTPA_GAP && op_checks_status(op_q)
							&& read_strobe_n_out) begin
						read_strobe_n_out <= 1'b0;
					end else if (!read_strobe_n_out) begin
						read_strobe_n_out <= 1'b1;
						status_q <= nand_io_in;
						if (nand_io_in[`OTPA_ST_READY_BIT]) begin
							pass_q <= !nand_io_in[`OTPA_ST_FAIL_BIT];
							if (op_q == `OTPA_OP_PROGRAM && protect_mode_q
									&& !nand_io_in[`OTPA_ST_FAIL_BIT]) begin
								protected_q <= 1'b1;
							end else if (op_q == `OTPA_OP_PROGRAM
									&& !nand_io_in[`OTPA_ST_FAIL_BIT]) begin
								partial_q <= (page_q == last_page_q) ? partial_q + 3'h1
									: 3'h1;
								last_page_q <= page_q;
							end
						end
						if (op_q == `OTPA_OP_READ) begin
							// Then fetch one byte by random data output
							state_q <= OTPA_CMD;
							op_q <= `OTPA_OP_RAND_OUT;
							idx_q <= 3'h0;
						end else begin
							busy_q <= 1'b0;
							done_q <= 1'b1;
							state_q <= OTPA_IDLE;
						end
					end else if (gap_q != 3'h0) begin
						gap_q <= gap_q - 3'h1;
					end else if (op_q == `OTPA_OP_RAND_OUT && idx_q != 3'h0) begin
						// Single byte fetch, one read strobe pulse, then OTPA_DIN
						read_strobe_n_out <= 1'b0;
						idx_q <= 3'h0;
						state_q <= OTPA_DIN;
					end else begin
						if (op_q == `OTPA_OP_ENTER) begin
							otp_mode_q <= 1'b1;
							protect_mode_q <= 1'b0;
						end else if (op_q == `OTPA_OP_PROTECT_MODE) begin
							protect_mode_q <= 1'b1;
							otp_mode_q <= 1'b0;
						end else if (op_q == `OTPA_OP_EXIT) begin
							otp_mode_q <= 1'b0;
							protect_mode_q <= 1'b0;
						end
						busy_q <= 1'b0;
						done_q <= 1'b1;
						pass_q <= 1'b1;
						state_q <= OTPA_IDLE;
					end
				end
				OTPA_DIN: begin
					read_strobe_n_out <= 1'b1;
					rdata_q <= nand_io_in;
					busy_q <= 1'b0;
					done_q <= 1'b1;
					state_q <= OTPA_IDLE;
				end
				default: begin
					state_q <= OTPA_IDLE;
				end
			endcase
			if (state_q == OTPA_STAT && phase_q == `OTPA_STROBE_CYC) begin
				idx_q <= 3'h1;
			end
		end
	end
endmodule

/* otpa_nand_model.sv */
// Behavioural model of the NAND device's one-time-programmable area.
// Assumes the host holds bytes across the rise of we_n and reads while read_strobe_n is low.
`timescale 1ns/1ps
module otpa_nand_model #(
	parameter int PROG_NS = 3000,
	parameter int READ_NS = 1500,
	parameter int OBSY_NS = 400
) (
	// NAND bus
	input wire logic ce_n_in,
	input wire logic cle_in,
	input wire logic ale_in,
	input wire logic we_n_in,
	input wire logic re_n_in,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic ready_out
);
	// ****************************************
	// Array, buffers and mode flags
	// ****************************************
	logic [7:0] mem_q [0:31][0:7];
	logic [7:0] buf_q [0:7];
	logic [7:0] ad_q [0:4];
	logic [7:0] cmd_q, page_q, dout;
	logic otp_q, prot_mode_q, protected_q, fail_q, stat_q;
	int na, nd, col;
	initial begin
		foreach (mem_q[p, c]) mem_q[p][c] = 8'hff;
		{otp_q, prot_mode_q, protected_q, fail_q, stat_q} = 5'h00;
		{cmd_q, page_q, na, nd, col} = '0;
		ready_out = 1'b1;
	end
	assign dout = stat_q ? {2'b00, ready_out, 4'h0, fail_q} : mem_q[page_q[4:0]][col[2:0]];
	// Released bus shows the inverse of the value it would drive now
	assign io_out = (!ce_n_in && !re_n_in) ? dout : ~dout;
	always @(posedge we_n_in) if (!ce_n_in) begin
		if (cle_in) begin
			{na, nd} = '0;
			stat_q = (io_in == 8'h70);
			if (io_in == 8'h80) foreach (buf_q[i]) buf_q[i] = 8'hff;
			if (io_in == 8'h10) begin
				ready_out = 1'b0;
				if (protected_q) begin
					fail_q = 1'b1;
					#(OBSY_NS);
				end else begin
					fail_q = 1'b0;
					if (prot_mode_q) protected_q = 1'b1;
					else if (otp_q && page_q >= 8'h02 && page_q <= 8'h1f)
						foreach (buf_q[i]) mem_q[page_q[4:0]][i] &= buf_q[i];
					#(PROG_NS);
				end
				ready_out = 1'b1;
			end else if (io_in == 8'h30) begin
				page_q = ad_q[2];
				col = ad_q[0];
				ready_out = 1'b0;
				#(READ_NS);
				ready_out = 1'b1;
			end else if (io_in == 8'he0) col = ad_q[0];
			else if (io_in != 8'h70) cmd_q = io_in;
		end else if (ale_in) begin
			if (na < 5) ad_q[na] = io_in;
			na++;
			if (na == 2) col = ad_q[0];
			if (na == 3 && cmd_q == 8'h80) page_q = ad_q[2];
		end else begin
			if (cmd_q == 8'hef && ad_q[0] == 8'h90 && nd == 0) begin
				otp_q = (io_in == 8'h01);
				prot_mode_q = (io_in == 8'h03);
			end else if (cmd_q == 8'h80 || cmd_q == 8'h85) begin
				buf_q[col[2:0]] &= io_in;
				col++;
			end
			nd++;
		end
	end
	always @(posedge re_n_in) if (!ce_n_in && !stat_q) col++;
endmodule

/* otpa_host_checker.sv */
// Port-level assertions for the OTP area host controller.
// Assumes it is bound to otpa_host and sees its ports only.
`timescale 1ns/1ps
module otpa_host_checker (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic nand_ce_n_out,
	input wire logic nand_cle_out,
	input wire logic nand_ale_out,
	input wire logic nand_we_n_out,
	input wire logic read_strobe_n_out,
	input wire logic [7:0] nand_io_out,
	input wire logic nand_io_oe_out,
	input wire logic nand_ready_in
);
	// ****************************************
	// Bus relations
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	we_pulse_a: assert property (!nand_we_n_out |=> nand_we_n_out && $stable(nand_io_out)
		&& $stable(nand_cle_out) && $stable(nand_ale_out)) else $error("write strobe shape");
	feat_addr_a: assert property (nand_cle_out && !nand_we_n_out && nand_io_out == 8'hef
		|-> ##2 nand_ale_out && !nand_we_n_out && nand_io_out == 8'h90) else $error("feature addr");
	busy_cmd_a: assert property (!nand_we_n_out && !nand_ready_in
		|-> nand_cle_out && nand_io_out == 8'h70) else $error("command while busy");
	sel_a: assert property (!nand_we_n_out || !read_strobe_n_out |-> !nand_ce_n_out)
		else $error("strobe without select");
	we_drive_a: assert property (!nand_we_n_out |-> nand_io_oe_out) else $error("io not driven");
	rd_release_a: assert property (!read_strobe_n_out |-> !nand_io_oe_out && nand_we_n_out)
		else $error("read while driving");
	latch_excl_a: assert property (!(nand_cle_out && nand_ale_out)) else $error("cle and ale");
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside slot");
	busy_seen_c: cover property (!nand_ready_in);
endmodule
bind otpa_host otpa_host_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .nand_ce_n_out(nand_ce_n_out), .nand_cle_out(nand_cle_out),
	.nand_ale_out(nand_ale_out), .nand_we_n_out(nand_we_n_out),
	.read_strobe_n_out(read_strobe_n_out), .nand_io_out(nand_io_out),
	.nand_io_oe_out(nand_io_oe_out), .nand_ready_in(nand_ready_in));

/* otpa_host_tb.sv */
// Self-checking testbench for the OTP area host controller.
// Assumes otpa_nand_model stands on the NAND bus.
`timescale 1ns/1ps
`include "otpa_regs.svh"
module otpa_host_tb;
	// ****************************************
	// Stimulus, tasks and sequence
	// ****************************************
	logic clk_in = 1'b0, rst_in = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic ce_n, cle, ale, we_n, re_n, oe, rdy;
	logic [7:0] io_h, io_d;
	int bad_count = 0, tests_run = 0;
	always #50 clk_in = ~clk_in;
	otpa_host dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .nand_ce_n_out(ce_n),
		.nand_cle_out(cle), .nand_ale_out(ale), .nand_we_n_out(we_n), .read_strobe_n_out(re_n),
		.nand_io_in(io_d), .nand_io_out(io_h), .nand_io_oe_out(oe), .nand_ready_in(rdy));
	otpa_nand_model dev (.ce_n_in(ce_n), .cle_in(cle), .ale_in(ale), .we_n_in(we_n),
		.re_n_in(re_n), .io_in(oe ? io_h : 8'h00), .io_out(io_d), .ready_out(rdy));
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_in);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(d & m, e);
	endtask
	task automatic op(input logic [2:0] c);
		logic [31:0] s;
		int n = 0;
		wr(`OTPA_ADDR_CTRL, {29'h0, c});
		do begin
			rd(`OTPA_ADDR_STATUS, s);
			n++;
		end while (s[1] !== 1'b0 && n < 3000);
		if (s[1] !== 1'b0) begin
			bad_count++;
			complete_run();
		end
	endtask
	task automatic acc(input logic [2:0] c, input logic [7:0] p, input logic [12:0] col,
		input logic [7:0] d);
		wr(`OTPA_ADDR_PAGE, {24'h0, p});
		wr(`OTPA_ADDR_COL, {19'h0, col});
		wr(`OTPA_ADDR_WDATA, {24'h0, d});
		op(c);
	endtask
	initial begin
		#5_000_000;
		bad_count++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		rdc(`OTPA_ADDR_WDATA, 32'hff, 32'hff);
		rdc(`OTPA_ADDR_COUNT, 32'hff, 32'h1);
		rdc(`OTPA_ADDR_STATUS, 32'h70, 32'h0);
		acc(`OTPA_OP_PROGRAM, 8'h02, 13'h0, 8'h5a);
		rdc(`OTPA_ADDR_STATUS, 32'h80, 32'h80);
		op(`OTPA_OP_ENTER);
		rdc(`OTPA_ADDR_STATUS, 32'h60, 32'h20);
		chk({31'h0, dev.otp_q}, 32'h1);
		acc(`OTPA_OP_PROGRAM, 8'h02, 13'h0, 8'h5a);
		rdc(`OTPA_ADDR_STATUS, 32'h88, 32'h08);
		rdc(`OTPA_ADDR_STATUS, 32'hff00, 32'h2000);
		acc(`OTPA_OP_READ, 8'h02, 13'h0, 8'hff);
		rdc(`OTPA_ADDR_RDATA, 32'hff, 32'h5a);
		wr(`OTPA_ADDR_COL, 32'h1);
		op(`OTPA_OP_RAND_OUT);
		rdc(`OTPA_ADDR_RDATA, 32'hff, 32'hff);
		acc(`OTPA_OP_RAND_IN, 8'h02, 13'h5, 8'ha5);
		chk({24'h0, dev.buf_q[5]}, 32'ha5);
		acc(`OTPA_OP_PROGRAM, 8'h03, 13'h1, 8'hf0);
		acc(`OTPA_OP_PROGRAM, 8'h03, 13'h1, 8'h3c);
		acc(`OTPA_OP_READ, 8'h03, 13'h1, 8'hff);
		rdc(`OTPA_ADDR_RDATA, 32'hff, 32'h30);
		for (int i = 0; i < 3; i++) begin
			acc(`OTPA_OP_PROGRAM, 8'h03, 13'h2, 8'hff);
			rdc(`OTPA_ADDR_STATUS, 32'h80, i == 2 ? 32'h80 : 32'h0);
		end
		acc(`OTPA_OP_PROGRAM, 8'h02, 13'h3, 8'h00);
		rdc(`OTPA_ADDR_STATUS, 32'h80, 32'h80);
		acc(`OTPA_OP_PROGRAM, 8'h20, 13'h0, 8'h00);
		rdc(`OTPA_ADDR_STATUS, 32'h80, 32'h80);
		op(`OTPA_OP_EXIT);
		rdc(`OTPA_ADDR_STATUS, 32'h60, 32'h0);
		op(`OTPA_OP_PROTECT_MODE);
		rdc(`OTPA_ADDR_STATUS, 32'h60, 32'h40);
		acc(`OTPA_OP_PROGRAM, 8'h04, 13'h0, 8'h00);
		rdc(`OTPA_ADDR_STATUS, 32'h98, 32'h18);
		chk({31'h0, dev.protected_q}, 32'h1);
		op(`OTPA_OP_EXIT);
		op(`OTPA_OP_ENTER);
		acc(`OTPA_OP_PROGRAM, 8'h04, 13'h0, 8'h00);
		rdc(`OTPA_ADDR_STATUS, 32'h90, 32'h90);
		acc(`OTPA_OP_READ, 8'h02, 13'h0, 8'hff);
		rdc(`OTPA_ADDR_RDATA, 32'hff, 32'h5a);
		op(`OTPA_OP_EXIT);
		complete_run();
	end
endmodule
